/* File: hw/plsr_map.vh */
// Constants for the parallel-load shift register block.
// Assumes inclusion by bare name from the design files.
`ifndef PLSR_MAP_VH
`define PLSR_MAP_VH
`define PLSR_STAGES     8
`define PLSR_LAST       7
`define PLSR_FIFO_DEPTH 8
`define PLSR_FIFO_AW    3
`define PLSR_ONE        1'b1
`define PLSR_ZERO       1'b0
`define PLSR_CNT_W      4
`define PLSR_CNT_ZERO   4'h0
`define PLSR_CNT_ONE    4'h1
`endif

/* File: hw/plsr_fifo.v */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`include "plsr_map.vh"
module plsr_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    // Fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output reg  [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            push;
    wire            pop;

    // Handshakes; full and empty come from the count
    assign in_ready_o  = (count_r != DEPTH[AW:0]);
    assign out_valid_o = (count_r != {(AW+1){1'b0}});
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Storage write, no reset on the array
    always @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // Pointers, count and registered head word
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r   <= {AW{1'b0}};
            rd_ptr_r   <= {AW{1'b0}};
            count_r    <= {(AW+1){1'b0}};
            out_data_o <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & ~pop) begin
                count_r <= count_r + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                count_r <= count_r - {{AW{1'b0}}, 1'b1};
            end
            // Head word: bypass when empty, else next entry
            if (pop) begin
                if (count_r == {{AW{1'b0}}, 1'b1}) begin
                    out_data_o <= in_data_i;
                end else begin
                    out_data_o <= mem_r[rd_ptr_r + {{(AW-1){1'b0}}, 1'b1}];
                end
            end else if (!out_valid_o) begin
                out_data_o <= in_data_i;
            end
        end
    end
endmodule // plsr_fifo

/* File: hw/plsr_top.v */
// Eight-stage shift register with parallel load and open-drain outputs.
// Assumes all inputs synchronous to clk_i; the load is applied each cycle
// while shift_not_load_i is low. Shifted-out bits go through a FIFO.
`timescale 1ns/1ns
`include "plsr_map.vh"

// Functional notes
// R1 - Chain of eight storage stages, parallel or serial fill, serial out.
// R2 - Shift_not_load low loads every stage from its parallel input.
// R3 - During load, outputs follow the last parallel input and its inverse.
// R4 - In shift mode stages hold until a qualified rising edge.
// R5 - Qualified edge: first stage takes serial in, others take predecessor; the code holds all stages instead while the FIFO is full.
// R6 - Data moves toward the output end; last stage value is lost.
// R7 - True output follows last stage, inverted output its complement.
// R8 - Clock_inhibit high blocks edges; stages keep values.
// R9 - Clock and inhibit interchangeable: rise of one while other low.
// R10 - Outputs pull low only when logically low, otherwise released.
// R11 - Stages have no defined reset value.
// R12 - Open-drain output shown as a drive-low enable.
module plsr_top (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_n_i,
    // Controller inputs
    input  wire       shift_not_load_i,
    input  wire       shift_clk_i,
    input  wire       clock_inhibit_i,
    input  wire       serial_i,
    input  wire [7:0] parallel_i,
    // Open-drain serial outputs
    output reg        ser_out_o,
    output reg        ser_out_oe_o,
    output reg        ser_out_n_o,
    output reg        ser_out_n_oe_o,
    // Stream of discarded bits
    output wire       lost_valid_o,
    input  wire       lost_ready_i,
    output wire       lost_data_o,
    // Status
    output reg        shift_stall_o,
    output reg [3:0]  shift_count_o
);
    reg  [`PLSR_LAST:0] stage_r;
    reg  [`PLSR_LAST:0] stage_nxt;
    reg                 clk_d_r;
    reg                 inh_d_r;
    reg  [`PLSR_CNT_W-1:0] count_nxt;
    wire                edge_q;
    wire                shift_go;
    wire                fifo_ready;
    wire                last_bit;

    // Qualified edge test on clock or inhibit
    function qual_edge;
        input c_now;
        input c_old;
        input i_now;
        input i_old;
        begin
            qual_edge = (c_now & ~c_old & ~i_now) |
                        (i_now & ~i_old & ~c_now);
        end
    endfunction

    // Previous levels of clock and inhibit, reset to high so no false edge
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_d_r <= `PLSR_ONE;
            inh_d_r <= `PLSR_ONE;
        end else begin
            clk_d_r <= shift_clk_i;
            inh_d_r <= clock_inhibit_i;
        end
    end

    // R9 either input edges
    assign edge_q = qual_edge(shift_clk_i, clk_d_r,
                              clock_inhibit_i, inh_d_r);
    // R8 inhibit blocks shift
    assign shift_go = shift_not_load_i & edge_q & fifo_ready;

    // Next stage contents
    always @* begin
        stage_nxt = stage_r;
        if (!shift_not_load_i) begin
            // R2 parallel load
            stage_nxt = parallel_i;
        end else if (shift_go) begin
            // R5 serial into first
            // R6 toward output end
            stage_nxt = {stage_r[`PLSR_LAST-1:0], serial_i};
        end
        // R4 hold otherwise
    end

    // R11 stages without reset
    always @(posedge clk_i) begin
        stage_r <= stage_nxt;
    end

    assign last_bit = stage_nxt[`PLSR_LAST];

    // Shift counter since last load
    always @* begin
        count_nxt = shift_count_o;
        if (!shift_not_load_i) begin
            count_nxt = `PLSR_CNT_ZERO;
        end else if (shift_go && shift_count_o != `PLSR_STAGES) begin
            count_nxt = shift_count_o + `PLSR_CNT_ONE;
        end
    end

    // Registered outputs from the next stage value
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ser_out_o      <= `PLSR_ZERO;
            ser_out_oe_o   <= `PLSR_ZERO;
            ser_out_n_o    <= `PLSR_ZERO;
            ser_out_n_oe_o <= `PLSR_ZERO;
            shift_stall_o  <= `PLSR_ZERO;
            shift_count_o  <= `PLSR_CNT_ZERO;
        end else begin
            // R3 load shows last input
            // R7 true and inverted
            ser_out_o      <= `PLSR_ZERO;
            ser_out_n_o    <= `PLSR_ZERO;
            // R10 pull low only
            // R12 drive-low enables
            ser_out_oe_o   <= ~last_bit;
            ser_out_n_oe_o <= last_bit;
            shift_stall_o  <= shift_not_load_i & edge_q & ~fifo_ready;
            shift_count_o  <= count_nxt;
        end
    end

    // R6 discarded bits queued
    plsr_fifo #(
        .WIDTH (1),
        .DEPTH (`PLSR_FIFO_DEPTH),
        .AW    (`PLSR_FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (shift_go),
        .in_ready_o  (fifo_ready),
        .in_data_i   (stage_r[`PLSR_LAST]),
        .out_valid_o (lost_valid_o),
        .out_ready_i (lost_ready_i),
        .out_data_o  (lost_data_o)
    );
endmodule // plsr_top

/* File: tb/plsr_checker.sv */
// Port properties of plsr_top.
// Assumes it is bound to every plsr_top instance.
`timescale 1ns/1ns
module plsr_checker (
    input wire       clk_i, rst_n_i, shift_not_load_i, shift_clk_i,
    input wire       clock_inhibit_i, ser_out_o, ser_out_oe_o,
    input wire       ser_out_n_o, ser_out_n_oe_o, lost_valid_o,
    input wire       shift_stall_o,
    input wire [7:0] parallel_i,
    input wire [3:0] shift_count_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    reg loaded_r;
    // Stages are known once a load was seen
    always @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i) loaded_r <= 1'b0;
        else if (!shift_not_load_i) loaded_r <= 1'b1;
    sequence loading;
        !shift_not_load_i && $stable(parallel_i);
    endsequence
    sequence quiet;
        shift_not_load_i && $stable(shift_clk_i) && $stable(clock_inhibit_i);
    endsequence
    sequence clk_rise;
        shift_not_load_i && $rose(shift_clk_i) && !clock_inhibit_i;
    endsequence
    sequence inh_rise;
        shift_not_load_i && $rose(clock_inhibit_i) && !shift_clk_i;
    endsequence
    AST_DRIVE_LOW: assert property (!ser_out_o && !ser_out_n_o)
        else $error("drive value not low");
    AST_ONE_LOW: assert property ($past(loaded_r, 2) |->
        ser_out_oe_o != ser_out_n_oe_o) else $error("pull-downs clash");
    AST_LOAD_OUT: assert property (loading [*3] |->
        ser_out_oe_o != parallel_i[7] && ser_out_n_oe_o == parallel_i[7])
        else $error("load output wrong");
    AST_LOAD_CNT: assert property (!shift_not_load_i [*2] |->
        shift_count_o == 4'h0) else $error("count not cleared");
    AST_HOLD: assert property (quiet [*4] |-> $stable(ser_out_oe_o)
        && $stable(shift_count_o)) else $error("stages moved");
    AST_INHIBIT: assert property ((shift_not_load_i && clock_inhibit_i)
        [*4] |-> $stable(shift_count_o)) else $error("inhibit ignored");
    AST_CLK_SHIFT: assert property (clk_rise |-> ##1
        (shift_stall_o || shift_count_o == 4'h8 ||
         shift_count_o != $past(shift_count_o)))
        else $error("clock edge lost");
    AST_INH_SHIFT: assert property (inh_rise |-> ##1
        (shift_stall_o || shift_count_o == 4'h8 ||
         shift_count_o != $past(shift_count_o)))
        else $error("inhibit edge lost");
endmodule // plsr_checker
bind plsr_top plsr_checker u_chk (.*);

/* File: tb/plsr_ctrl_model.sv */
// Controller model: takes discarded bits, reads the serial lines.
// Assumes clk_i is the block clock; stall_i stops acceptance.
`timescale 1ns/1ns
module plsr_ctrl_model (
    input  wire clk_i, stall_i, oe_i, n_oe_i,
    output reg  ready_o,
    output wire line_o, line_n_o
);
    initial ready_o = 1'b0;
    // Accepts every other cycle, a slow consumer
    always @(negedge clk_i) ready_o <= !stall_i && !ready_o;
    assign line_o   = oe_i ? 1'b0 : 1'b1;
    assign line_n_o = n_oe_i ? 1'b0 : 1'b1;
endmodule // plsr_ctrl_model

/* File: tb/plsr_tb_top.sv */
// Bench: loads, shifts three ways and fills the FIFO.
// Assumes plsr_top, the model and the checker are compiled.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module plsr_tb_top;
    reg        clk_i = 0, rst_n_i = 0, sl = 0, sc = 0, ci = 0, si = 0;
    reg        hold = 0, stalled = 0, e;
    reg  [7:0] par = 8'h00, m;
    wire       oe, n_oe, lv, rdy, ld, stall, q, q_n;
    wire [3:0] cnt;
    integer    n_mismatch = 0, checked = 0, seed = 94, i, j, k;
    reg        exp_q[$];
    plsr_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .shift_not_load_i(sl),
        .shift_clk_i(sc), .clock_inhibit_i(ci), .serial_i(si),
        .parallel_i(par), .ser_out_o(), .ser_out_oe_o(oe), .ser_out_n_o(),
        .ser_out_n_oe_o(n_oe), .lost_valid_o(lv), .lost_ready_i(rdy),
        .lost_data_o(ld), .shift_stall_o(stall), .shift_count_o(cnt));
    plsr_ctrl_model u_ctrl (.clk_i(clk_i), .stall_i(hold), .oe_i(oe),
        .n_oe_i(n_oe), .ready_o(rdy), .line_o(q), .line_n_o(q_n));
    initial forever #5 clk_i = ~clk_i;
    // Each popped bit against the oldest note
    always @(posedge clk_i) begin
        if (lv && rdy) begin
            e = exp_q.pop_front();
            `CHK(ld, e)
        end
        if (stall) stalled <= 1'b1;
    end
    // One shift: clock pulse, inhibit pulse, or both overlapped
    task shift(input integer mode, input reg ok, input [3:0] c);
        begin
            k = $random(seed);
            si = k[0];
            if (ok) exp_q.push_back(m[7]);
            if (ok) m = {m[6:0], si};
            if (mode == 1) ci = 1; else sc = 1;
            @(negedge clk_i);
            if (mode == 2) ci = 1;
            @(negedge clk_i);
            sc = 0;
            @(negedge clk_i);
            ci = 0;
            repeat (3) @(negedge clk_i);
            `CHK({q, q_n, cnt}, {m[7], ~m[7], c})
        end
    endtask
    task close_out;
        begin
            if (n_mismatch == 0 && checked > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(negedge clk_i);
        rst_n_i = 1;
        for (i = 0; i < 6; i++) begin
            k = $random(seed);
            par = k[7:0];
            m = par;
            sl = 0;
            repeat (3) @(negedge clk_i);
            `CHK({q, q_n, cnt}, {m[7], ~m[7], 4'h0})
            sl = 1;
            hold = (i == 5);
            for (j = 0; j < 8; j++) shift(j % 3, 1, j + 1);
        end
        shift(0, 0, 4'h8);
        hold = 0;
        repeat (40) @(negedge clk_i);
        `CHK({stalled, exp_q.size() == 0}, 2'b11)
        close_out;
    end
    initial begin
        #100000;
        n_mismatch++;
        close_out;
    end
endmodule // plsr_tb_top
